// *** level_watchdog.sv ***
`timescale 1ns/1ns
`default_nettype none
module level_watchdog
  import ref_switch_pkg::*;
#(
  parameter int unsigned WINDOW = FAIL_WINDOW_CYC
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // watched level
  input  wire logic sig_i,
  // status
  output logic      dead_o,
  output logic      rise_o,
  output logic      fall_o
);
  localparam int CW = $clog2(WINDOW + 1);

  logic          prev_q, prev_d;
  logic [CW-1:0] cnt_q,  cnt_d;
  logic          dead_q, dead_d;
  logic          change;

  always_comb begin
    change = sig_i ^ prev_q;
    prev_d = sig_i;
    // saturate so a long stall never wraps back to healthy
    if (change) begin
      cnt_d = '0;
    end else if (cnt_q == CW'(WINDOW)) begin
      cnt_d = cnt_q;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
    dead_d = !change && (cnt_q >= CW'(WINDOW - 1));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= 1'b0;
      cnt_q  <= '0;
      dead_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      cnt_q  <= cnt_d;
      dead_q <= dead_d;
    end
  end

  assign dead_o = dead_q;
  assign rise_o = sig_i & !prev_q;
  assign fall_o = !sig_i & prev_q;
endmodule
`default_nettype wire

// *** redundant_ref_clock_switch.sv ***
// Notes on behaviour
// - input counts as failed after staying high or low one full input period
// - both inputs lost sets both failure flags and stalls the reference
// - only stopped clocks are detected, frequency changes are ignored
// - auto mode monitors both inputs, failure shows as its flag going low
// - a failure flag stays latched until alarm clear or soft clear
// - auto mode fails over to secondary only if valid, indicator follows
// - indicator 0 means input a active, 1 means input b active
// - manual mode still monitors, reference follows select pin unless both inputs are lost
// - any reference change waits for falling edge of new input
// - slew starts at next rising edge of both, no runt pulses
// - falling edge of alarm clear makes one pulse clearing flags and indicator latch
// - both invalid at clear relatch flags after one feedback period, indicator low
// - with no flag latched the indicator follows the select pin
// - output-off/divider reset leaves flags and indicator untouched
`timescale 1ns/1ns
`default_nettype none
module redundant_ref_clock_switch
  import ref_switch_pkg::*;
#(
  parameter int unsigned FAIL_WINDOW = FAIL_WINDOW_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // reference and feedback inputs
  input  wire logic        ref_input_a_i,
  input  wire logic        ref_input_b_i,
  input  wire logic        loop_return_clk_i,
  // board control
  input  wire logic        auto_switch_sel_i,
  input  wire logic        ref_sel_i,
  input  wire logic        alarm_clear_n_i,
  input  wire logic        output_off_and_divreset_i,
  // status and reference out
  output logic             input_fail_flag_a_n_o,
  output logic             input_fail_flag_b_n_o,
  output logic             active_ref_flag_o,
  output logic             ref_clk_o,
  output logic             slew_start_o,
  output logic             div_reset_o,
  output logic             irq_o
);
  // pick a or b by index
  function automatic logic pick(input logic sel, input logic a, input logic b);
    return sel ? b : a;
  endfunction

  logic dead_a, dead_b, rise_a, rise_b, fall_a, fall_b;

  level_watchdog #(.WINDOW(FAIL_WINDOW)) u_mon_a (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .sig_i  (ref_input_a_i),
    .dead_o (dead_a),
    .rise_o (rise_a),
    .fall_o (fall_a)
  );

  level_watchdog #(.WINDOW(FAIL_WINDOW)) u_mon_b (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .sig_i  (ref_input_b_i),
    .dead_o (dead_b),
    .rise_o (rise_b),
    .fall_o (fall_b)
  );

  // synchronisers, first stage feeds only the second
  logic [2:0] sync1_q, sync1_d, sync2_q, sync2_d;
  logic       clr_prev_q, clr_prev_d, fb_prev_q, fb_prev_d;
  logic       auto_s, sel_s, clr_s, clr_pulse, fb_rise;

  always_comb begin
    sync1_d    = {alarm_clear_n_i, ref_sel_i, auto_switch_sel_i};
    sync2_d    = sync1_q;
    clr_prev_d = sync2_q[2];
    fb_prev_d  = loop_return_clk_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q    <= 3'h4;
      sync2_q    <= 3'h4;
      clr_prev_q <= 1'b1;
      fb_prev_q  <= 1'b0;
    end else begin
      sync1_q    <= sync1_d;
      sync2_q    <= sync2_d;
      clr_prev_q <= clr_prev_d;
      fb_prev_q  <= fb_prev_d;
    end
  end

  // software clear strobe, self clearing
  logic soft_clr_q, soft_clr_d;
  logic wr_en;

  assign auto_s    = sync2_q[0];
  assign sel_s     = sync2_q[1];
  assign clr_s     = sync2_q[2];
  assign clr_pulse = (!clr_s && clr_prev_q) || soft_clr_q;
  assign fb_rise   = loop_return_clk_i && !fb_prev_q;

  // flags, selection and slew tracking
  logic       fail_a_n_q, fail_a_n_d, fail_b_n_q, fail_b_n_d;
  logic       active_q, active_d, ref_q, ref_d;
  logic       blank_q, blank_d;
  logic [1:0] fb_cnt_q, fb_cnt_d;
  logic       arm_q, arm_d, seen_ref_q, seen_ref_d, seen_fb_q, seen_fb_d, slew_q, slew_d;
  logic       divrst_q, divrst_d;
  logic       both_lost, target, tgt_fall, old_low, switch_now, ref_now_rise;

  always_comb begin
    fail_a_n_d = fail_a_n_q;
    fail_b_n_d = fail_b_n_q;
    blank_d    = blank_q;
    fb_cnt_d   = fb_cnt_q;
    // clear opens a one feedback period blanking window
    if (clr_pulse) begin
      fail_a_n_d = 1'b1;
      fail_b_n_d = 1'b1;
      blank_d    = 1'b1;
      fb_cnt_d   = '0;
    end else begin
      if (blank_q && fb_rise) begin
        fb_cnt_d = fb_cnt_q + 1'b1;
        if (fb_cnt_d == BLANK_FB_EDGES) begin
          blank_d = 1'b0;
        end
      end
      // latched in both modes, only alarm clear or soft clear releases
      if (!blank_q && dead_a) begin
        fail_a_n_d = 1'b0;
      end
      if (!blank_q && dead_b) begin
        fail_b_n_d = 1'b0;
      end
    end
    // output-off never touches flags or indicator
    divrst_d  = output_off_and_divreset_i;
    both_lost = !fail_a_n_q && !fail_b_n_q;
    // frequency is not examined, only stalls matter
    if (!auto_s || (fail_a_n_q && fail_b_n_q)) begin
      target = sel_s;
    end else if (!pick(sel_s, fail_a_n_q, fail_b_n_q) && pick(!sel_s, fail_a_n_q, fail_b_n_q)) begin
      target = !sel_s;
    end else begin
      target = active_q;
    end
    tgt_fall   = pick(target, fall_a, fall_b);
    // old input must already be low, or dead, else its high phase is cut
    old_low    = !pick(active_q, ref_input_a_i, ref_input_b_i) || pick(active_q, dead_a, dead_b);
    switch_now = !both_lost && (target != active_q) && tgt_fall && old_low;
    active_d   = active_q;
    if (both_lost) begin
      active_d = 1'b0;
    end else if (switch_now) begin
      active_d = target;
    end
    // loop stalls when nothing valid is left
    ref_d = both_lost ? 1'b0 : pick(active_d, ref_input_a_i, ref_input_b_i);
    ref_now_rise = pick(active_q, rise_a, rise_b);
    arm_d      = arm_q;
    seen_ref_d = seen_ref_q;
    seen_fb_d  = seen_fb_q;
    slew_d     = 1'b0;
    if (switch_now) begin
      arm_d      = 1'b1;
      seen_ref_d = 1'b0;
      seen_fb_d  = 1'b0;
    end else if (arm_q) begin
      seen_ref_d = seen_ref_q || ref_now_rise;
      seen_fb_d  = seen_fb_q || fb_rise;
      if (seen_ref_d && seen_fb_d) begin
        slew_d = 1'b1;
        arm_d  = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fail_a_n_q <= 1'b1;
      fail_b_n_q <= 1'b1;
      blank_q    <= 1'b0;
      fb_cnt_q   <= '0;
      active_q   <= 1'b0;
      ref_q      <= 1'b0;
      arm_q      <= 1'b0;
      seen_ref_q <= 1'b0;
      seen_fb_q  <= 1'b0;
      slew_q     <= 1'b0;
      divrst_q   <= 1'b0;
    end else begin
      fail_a_n_q <= fail_a_n_d;
      fail_b_n_q <= fail_b_n_d;
      blank_q    <= blank_d;
      fb_cnt_q   <= fb_cnt_d;
      active_q   <= active_d;
      ref_q      <= ref_d;
      arm_q      <= arm_d;
      seen_ref_q <= seen_ref_d;
      seen_fb_q  <= seen_fb_d;
      slew_q     <= slew_d;
      divrst_q   <= divrst_d;
    end
  end

  // wishbone slave, ack one cycle after request, write at the ack edge
  logic [IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d, events;
  logic             ack_q, ack_d, irq_q, irq_d;
  logic [31:0]      rdat_q, rdat_d;

  always_comb begin
    ack_d  = wb_cyc_i && wb_stb_i && !ack_q;
    wr_en  = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
    rdat_d = rdat_q;
    if (ack_d) begin
      rdat_d = 32'h0;
      case (wb_adr_i)
        ADDR_STATUS: begin
          rdat_d[ST_FAIL_A]  = !fail_a_n_q;
          rdat_d[ST_FAIL_B]  = !fail_b_n_q;
          rdat_d[ST_ACTIVE]  = active_q;
          rdat_d[ST_AUTO]    = auto_s;
          rdat_d[ST_DEAD_A]  = dead_a;
          rdat_d[ST_DEAD_B]  = dead_b;
          rdat_d[ST_SEL_PIN] = sel_s;
        end
        ADDR_IRQ_STAT: rdat_d[IRQ_W-1:0] = ist_q;
        ADDR_IRQ_MASK: rdat_d[IRQ_W-1:0] = imask_q;
        default:       rdat_d = 32'h0;
      endcase
    end
    soft_clr_d = wr_en && (wb_adr_i == ADDR_CTRL) && wb_dat_i[CTRL_SOFT_CLR];
    imask_d    = (wr_en && wb_adr_i == ADDR_IRQ_MASK) ? wb_dat_i[IRQ_W-1:0] : imask_q;
    events             = '0;
    events[EV_FAIL_A]  = fail_a_n_q && !fail_a_n_d;
    events[EV_FAIL_B]  = fail_b_n_q && !fail_b_n_d;
    events[EV_SWITCH]  = active_q != active_d;
    // a new event beats a write-one-to-clear in the same cycle
    ist_d = ist_q;
    if (wr_en && wb_adr_i == ADDR_IRQ_STAT) begin
      ist_d = ist_q & ~wb_dat_i[IRQ_W-1:0];
    end
    ist_d = ist_d | events;
    irq_d = |(ist_q & imask_q);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q      <= 1'b0;
      rdat_q     <= 32'h0;
      soft_clr_q <= 1'b0;
      imask_q    <= IRQ_MASK_RST;
      ist_q      <= '0;
      irq_q      <= 1'b0;
    end else begin
      ack_q      <= ack_d;
      rdat_q     <= rdat_d;
      soft_clr_q <= soft_clr_d;
      imask_q    <= imask_d;
      ist_q      <= ist_d;
      irq_q      <= irq_d;
    end
  end

  assign wb_ack_o              = ack_q;
  assign wb_dat_o              = rdat_q;
  assign input_fail_flag_a_n_o = fail_a_n_q;
  assign input_fail_flag_b_n_o = fail_b_n_q;
  assign active_ref_flag_o     = active_q;
  assign ref_clk_o             = ref_q;
  assign slew_start_o          = slew_q;
  assign div_reset_o           = divrst_q;
  assign irq_o                 = irq_q;

  // checks
  sequence s_clear_fall;
    alarm_clear_n_i ##1 !alarm_clear_n_i [*3];
  endsequence

  property p_dead_latch;
    @(posedge clk_i) disable iff (rst_i) (dead_a && !blank_q && !clr_pulse) |=> !input_fail_flag_a_n_o;
  endproperty
  a_dead_latch: assert property (p_dead_latch) else $error("dead input a not flagged");

  property p_flag_hold;
    @(posedge clk_i) disable iff (rst_i) (!input_fail_flag_b_n_o && !clr_pulse) |=> !input_fail_flag_b_n_o;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag b released without clear");

  property p_switch_edge;
    @(posedge clk_i) disable iff (rst_i) (active_ref_flag_o != $past(active_ref_flag_o) && active_ref_flag_o)
      |-> $past(fall_b);
  endproperty
  a_switch_edge: assert property (p_switch_edge) else $error("switch to b off its falling edge");

  property p_slew;
    @(posedge clk_i) disable iff (rst_i) slew_start_o |-> $past(arm_q) && $past(seen_fb_d) && $past(seen_ref_d);
  endproperty
  a_slew: assert property (p_slew) else $error("slew start without both rising edges");

  property p_clear;
    @(posedge clk_i) disable iff (rst_i) clr_pulse |=> input_fail_flag_a_n_o && input_fail_flag_b_n_o;
  endproperty
  a_clear: assert property (p_clear) else $error("clear pulse left a flag set");

  property p_both_low;
    @(posedge clk_i) disable iff (rst_i) (!input_fail_flag_a_n_o && !input_fail_flag_b_n_o)
      |=> !active_ref_flag_o && !ref_clk_o;
  endproperty
  a_both_low: assert property (p_both_low) else $error("both failed but indicator not low");

  property p_divrst;
    @(posedge clk_i) disable iff (rst_i) output_off_and_divreset_i && input_fail_flag_a_n_o && !dead_a
      |=> div_reset_o && input_fail_flag_a_n_o;
  endproperty
  a_divrst: assert property (p_divrst) else $error("output-off disturbed flags or divider reset");

  property p_sync_clear;
    @(posedge clk_i) disable iff (rst_i) s_clear_fall |-> clr_pulse;
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("alarm clear fall not seen two cycles later");

  property p_irq;
    @(posedge clk_i) disable iff (rst_i) (|(ist_q & imask_q)) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked event without interrupt");
endmodule
`default_nettype wire

// *** ref_source_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module ref_source_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // source control
  input  wire logic [1:0] run_i,
  input  wire logic [1:0] stuck_i,
  input  wire logic [3:0] half_b_i,
  // clocks out
  output logic      [1:0] ref_o,
  output logic            fb_o
);
  logic [3:0] cnt_a_q;
  logic [3:0] cnt_b_q;
  // a stopped source holds a level, it does not float
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_a_q <= 4'h0;
      cnt_b_q <= 4'h0;
      ref_o   <= 2'h0;
      fb_o    <= 1'b0;
    end else begin
      fb_o    <= ~fb_o;
      cnt_a_q <= (cnt_a_q >= 4'h1) ? 4'h0 : cnt_a_q + 4'h1;
      cnt_b_q <= (cnt_b_q + 4'h1 >= half_b_i) ? 4'h0 : cnt_b_q + 4'h1;
      ref_o[0] <= run_i[0] ? ((cnt_a_q >= 4'h1) ? ~ref_o[0] : ref_o[0]) : stuck_i[0];
      // period of b may change on the fly
      ref_o[1] <= run_i[1] ? ((cnt_b_q + 4'h1 >= half_b_i) ? ~ref_o[1] : ref_o[1]) : stuck_i[1];
    end
  end
endmodule
`default_nettype wire

// *** ref_switch_pkg.sv ***
`default_nettype none
package ref_switch_pkg;
  // register byte offsets
  localparam logic [3:0] ADDR_CTRL        = 4'h0;
  localparam logic [3:0] ADDR_STATUS      = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT    = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK    = 4'hC;
  // control fields
  localparam int         CTRL_SOFT_CLR    = 0;
  // status fields
  localparam int         ST_FAIL_A        = 0;
  localparam int         ST_FAIL_B        = 1;
  localparam int         ST_ACTIVE        = 2;
  localparam int         ST_AUTO          = 3;
  localparam int         ST_DEAD_A        = 4;
  localparam int         ST_DEAD_B        = 5;
  localparam int         ST_SEL_PIN       = 6;
  // event fields, shared by irq status and mask
  localparam int         IRQ_W            = 3;
  localparam int         EV_FAIL_A        = 0;
  localparam int         EV_FAIL_B        = 1;
  localparam int         EV_SWITCH        = 2;
  localparam logic [2:0] IRQ_MASK_RST     = 3'h0;
  // timing
  localparam int         CLK_PERIOD_NS    = 100;
  localparam int         REF_PERIOD_NS    = 1000;
  localparam int         FAIL_WINDOW_CYC  = (REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] BLANK_FB_EDGES   = 2'h2;
endpackage
`default_nettype wire

// *** test_redundant_ref_clock_switch.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_redundant_ref_clock_switch
  import ref_switch_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, auto_sel, sel, clr_n, off;
  logic [3:0]  adr, half_b;
  logic [31:0] wdat, rdat, dat_o;
  logic [1:0]  run, stuck, refs;
  logic        fb, fa_n, fb_n, act, rclk, slew, divr, irq, ack;
  int          num_errors, n_checks, m_fa, m_fb, m_act, m_stat, m_mask;

  always #50 clk_i = ~clk_i;

  ref_source_model i_ref_source_model (
    .clk_i(clk_i), .rst_i(rst_i), .run_i(run), .stuck_i(stuck), .half_b_i(half_b), .ref_o(refs), .fb_o(fb));

  redundant_ref_clock_switch #(.FAIL_WINDOW(4)) i_redundant_ref_clock_switch (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .ref_input_a_i(refs[0]),
    .ref_input_b_i(refs[1]), .loop_return_clk_i(fb), .auto_switch_sel_i(auto_sel), .ref_sel_i(sel),
    .alarm_clear_n_i(clr_n), .output_off_and_divreset_i(off), .input_fail_flag_a_n_o(fa_n),
    .input_fail_flag_b_n_o(fb_n), .active_ref_flag_o(act), .ref_clk_o(rclk), .slew_start_o(slew),
    .div_reset_o(divr), .irq_o(irq));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one classic cycle, waits up to 20 cycles for ack, ends the run if none comes
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      chk("wb ack", 32'h1, 32'h0);
      complete_run();
    end
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return fa_n;
      1: return fb_n;
      2: return act;
      default: return slew;
    endcase
  endfunction

  task automatic wait_for(input int k, input logic v);
    int n;
    n = 0;
    while (pick(k) !== v && n < 80) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 80) begin
      chk("wait bound", 32'h0, 32'h1);
      complete_run();
    end
  endtask

  task automatic model_chk();
    chk("fail_a_n", 32'(m_fa == 0), {31'h0, fa_n});
    chk("fail_b_n", 32'(m_fb == 0), {31'h0, fb_n});
    chk("active", 32'(m_act), {31'h0, act});
    chk("irq", 32'((m_stat & m_mask) != 0), {31'h0, irq});
  endtask

  initial begin
    {cyc, stb, we, auto_sel, sel} = 5'h00;
    adr = 4'h0;
    wdat = 32'h0;
    clr_n = 1'b1;
    off = 1'b1;
    run = 2'h3;
    stuck = 2'h0;
    half_b = 4'h2;
    m_fa = 0;
    m_fb = 0;
    m_act = 0;
    m_stat = 0;
    m_mask = 0;
    void'($urandom(76));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk("div_reset", 32'h1, {31'h0, divr});
    off <= 1'b0;
    clr_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    clr_n <= 1'b1;
    repeat (12) @(posedge clk_i);
    model_chk();
    rd(ADDR_STATUS, 32'h0, "status");
    rd(ADDR_IRQ_MASK, 32'(IRQ_MASK_RST), "mask reset");
    wb(1'b1, 4'h2, 32'hFFFF_FFFF);
    rd(4'h2, 32'h0, "unmapped");
    rd(ADDR_IRQ_STAT, 32'h0, "irq stat");
    // manual mode, both selections
    for (int s = 1; s >= 0; s--) begin
      sel <= 1'(s);
      wait_for(2, 1'(s));
      m_act = s;
      m_stat = 1 << EV_SWITCH;
      model_chk();
      rd(ADDR_IRQ_STAT, 32'(m_stat), "switch event");
      wb(1'b1, ADDR_IRQ_STAT, 32'(m_stat));
      m_stat = 0;
      rd(ADDR_IRQ_STAT, 32'h0, "w1c");
    end
    m_mask = 7;
    wb(1'b1, ADDR_IRQ_MASK, 32'h7);
    rd(ADDR_IRQ_MASK, 32'h7, "mask rw");
    auto_sel <= 1'b1;
    repeat (4) @(posedge clk_i);
    // primary stops at a random level
    stuck[0] <= 1'($urandom);
    run[0] <= 1'b0;
    wait_for(0, 1'b0);
    m_fa = 1;
    m_stat = (1 << EV_FAIL_A) | (1 << EV_SWITCH);
    wait_for(2, 1'b1);
    m_act = 1;
    wait_for(3, 1'b1);
    model_chk();
    rd(ADDR_STATUS, 32'((1 << ST_FAIL_A) | (1 << ST_ACTIVE) | (1 << ST_AUTO) | (1 << ST_DEAD_A)), "status a");
    rd(ADDR_IRQ_STAT, 32'(m_stat), "irq a");
    // frequency change on b goes unreported
    half_b <= 4'h1 + 4'($urandom % 3);
    repeat (40) @(posedge clk_i);
    model_chk();
    // odd half period keeps some falls of a inside low phases of b
    half_b <= 4'h3;
    run[0] <= 1'b1;
    repeat (30) @(posedge clk_i);
    model_chk();
    off <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("div_reset", 32'h1, {31'h0, divr});
    model_chk();
    off <= 1'b0;
    m_mask = 0;
    wb(1'b1, ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk_i);
    model_chk();
    wb(1'b1, ADDR_IRQ_STAT, 32'h7);
    m_stat = 0;
    rd(ADDR_IRQ_STAT, 32'h0, "w1c all");
    m_mask = 7;
    wb(1'b1, ADDR_IRQ_MASK, 32'h7);
    // soft clear unlatches flag and indicator
    wb(1'b1, ADDR_CTRL, 32'h1 << CTRL_SOFT_CLR);
    wait_for(0, 1'b1);
    m_fa = 0;
    wait_for(2, 1'b0);
    m_act = 0;
    m_stat = 1 << EV_SWITCH;
    // irq lags the status bit by one cycle
    @(posedge clk_i);
    model_chk();
    // both sources lost
    stuck <= 2'($urandom);
    run <= 2'h0;
    wait_for(0, 1'b0);
    wait_for(1, 1'b0);
    m_fa = 1;
    m_fb = 1;
    m_stat = m_stat | 3;
    repeat (2) @(posedge clk_i);
    chk("ref_clk", 32'h0, {31'h0, rclk});
    model_chk();
    clr_n <= 1'b0;
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    wait_for(1, 1'b0);
    clr_n <= 1'b1;
    model_chk();
    complete_run();
  end
endmodule
`default_nettype wire
